// ==== inc/upr_cfg.svh ====
// Offsets, field positions, reset values and masks of the pin routing block.
`ifndef UPR_CFG_SVH
`define UPR_CFG_SVH

// ==========================================
// Register addresses
`define UPR_ADDR_PFUNC1 16'hFF20
`define UPR_ADDR_PDIR1 16'hFF21
`define UPR_ADDR_PDIR11 16'hFF2B
`define UPR_ADDR_ISWC 16'hFF4F
`define UPR_ADDR_SMODE 16'hFF50

// ==========================================
// Reset values and masks
`define UPR_RST_PFUNC1 8'h00
`define UPR_RST_PDIR1 8'hFF
`define UPR_RST_PDIR11 8'hFF
`define UPR_RST_ISWC 8'h00
`define UPR_RST_SMODE 8'h01
`define UPR_WM_PFUNC1 8'h48
`define UPR_WM_PDIR1 8'hFF
`define UPR_WM_PDIR11 8'h0F
`define UPR_ONES_PDIR11 8'hF0
`define UPR_WM_ISWC 8'h3F
`define UPR_WM_SMODE 8'hFF

// ==========================================
// Field positions
`define UPR_ISWC_PAIR_HI 5
`define UPR_ISWC_PAIR_LO 4
`define UPR_ISWC_RX_GATE 3
`define UPR_ISWC_T52_GATE 2
`define UPR_ISWC_T00_SRC 1
`define UPR_ISWC_INT0_SRC 0
`define UPR_PF_PIN6 6
`define UPR_PF_PIN3 3
`define UPR_SM_POWER 7
`define UPR_SM_TXE 6
`define UPR_SM_RXE 5

`endif

// ==== inc/upr_pkg.sv ====
// Types shared by the pin routing block.
package upr_pkg;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic [7:0] wmask;
	} upr_cpu_req_t;

	typedef struct packed {
		logic out;
		logic oe_n;
	} upr_pin_drv_t;

	typedef enum logic {
		UPR_ROUTE_P11 = 1'b0,
		UPR_ROUTE_P1 = 1'b1
	} upr_route_t;

endpackage : upr_pkg

// ==== hdl/upr_reg8.sv ====
// One 8-bit control register with masked bit or byte writes.
`timescale 1ns/10ps
module upr_reg8 import upr_pkg::*; #(
	parameter logic [7:0] RST = 8'h00,
	parameter logic [7:0] WMASK = 8'hFF,
	parameter logic [7:0] ONES = 8'h00
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Write port
	input wire logic we,
	input wire logic [7:0] wdata,
	input wire logic [7:0] wmask,
	// Stored value
	output logic [7:0] q
);
	logic [7:0] q_reg;
	logic [7:0] keep;

	assign keep = wmask & WMASK;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q_reg <= RST;
		end else if (we) begin
			q_reg <= (q_reg & ~keep) | (wdata & keep);
		end
	end

	// Fixed bits read as their constant whatever was written.
	assign q = (q_reg & WMASK) | ONES;
endmodule : upr_reg8

// ==== hdl/upr_pin_cell.sv ====
// Registered driver for one two-way port pin.
`timescale 1ns/10ps
module upr_pin_cell import upr_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Chosen level and direction bit
	input wire logic level,
	input wire logic dir_in,
	// Pin drive
	output upr_pin_drv_t drv
);
	upr_pin_drv_t drv_reg;

	// A direction bit of 1 turns the output buffer off.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			drv_reg <= '{out: 1'b1, oe_n: 1'b1};
		end else begin
			drv_reg <= '{out: level, oe_n: dir_in};
		end
	end

	assign drv = drv_reg;
endmodule : upr_pin_cell

// ==== hdl/upr_top.sv ====
// Pin routing and stop control around the asynchronous serial unit.
`timescale 1ns/10ps
`include "upr_cfg.svh"

module upr_top import upr_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register access
	input upr_cpu_req_t cpu_req,
	output logic [7:0] cpu_rdata,
	// Port latches and other pin users
	input wire logic [7:0] port1_latch,
	input wire logic [3:0] port11_latch,
	input wire logic clocked_serial_a_act,
	input wire logic clocked_serial_a_out,
	input wire logic clocked_serial10_act,
	input wire logic clocked_serial10_out,
	input wire logic serial0_tx,
	// Serial unit core side
	input wire logic serial_tx,
	output logic serial_rx,
	output logic [4:0] serial_format,
	output logic unit_clk_run,
	output logic unit_async_rst,
	output logic tx_sync_rst,
	output logic rx_sync_rst,
	// Timer and interrupt inputs
	input wire logic timer00_pin,
	input wire logic extint0_pin,
	input wire logic timer52_pin,
	input wire logic timer_h2_output,
	output logic timer00_capture_in,
	output logic external_interrupt_0,
	output logic timer52_count_in,
	// Pins
	input wire logic p16_in,
	input wire logic p15_in,
	input wire logic p13_in,
	input wire logic p112_in,
	input wire logic p113_in,
	output upr_pin_drv_t p16_drv,
	output upr_pin_drv_t p13_drv,
	output upr_pin_drv_t p112_drv
);

	// ==========================================
	// Register decode
	function automatic logic hit(input upr_cpu_req_t r, input logic [15:0] a);
		hit = r.addr == a;
	endfunction : hit

	logic [7:0] pfunc1;
	logic [7:0] pdir1;
	logic [7:0] pdir11;
	logic [7:0] iswc;
	logic [7:0] smode;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	upr_reg8 #(.RST(`UPR_RST_PFUNC1), .WMASK(`UPR_WM_PFUNC1), .ONES(8'h00)) u_pfunc1 (
		.clk(clk), .sys_rst(sys_rst), .we(cpu_req.wr && hit(cpu_req, `UPR_ADDR_PFUNC1)),
		.wdata(cpu_req.wdata), .wmask(cpu_req.wmask), .q(pfunc1));

	upr_reg8 #(.RST(`UPR_RST_PDIR1), .WMASK(`UPR_WM_PDIR1), .ONES(8'h00)) u_pdir1 (
		.clk(clk), .sys_rst(sys_rst), .we(cpu_req.wr && hit(cpu_req, `UPR_ADDR_PDIR1)),
		.wdata(cpu_req.wdata), .wmask(cpu_req.wmask), .q(pdir1));

	upr_reg8 #(.RST(`UPR_RST_PDIR11), .WMASK(`UPR_WM_PDIR11), .ONES(`UPR_ONES_PDIR11))
	u_pdir11 (
		.clk(clk), .sys_rst(sys_rst), .we(cpu_req.wr && hit(cpu_req, `UPR_ADDR_PDIR11)),
		.wdata(cpu_req.wdata), .wmask(cpu_req.wmask), .q(pdir11));

	upr_reg8 #(.RST(`UPR_RST_ISWC), .WMASK(`UPR_WM_ISWC), .ONES(8'h00)) u_iswc (
		.clk(clk), .sys_rst(sys_rst), .we(cpu_req.wr && hit(cpu_req, `UPR_ADDR_ISWC)),
		.wdata(cpu_req.wdata), .wmask(cpu_req.wmask), .q(iswc));

	upr_reg8 #(.RST(`UPR_RST_SMODE), .WMASK(`UPR_WM_SMODE), .ONES(8'h00)) u_smode (
		.clk(clk), .sys_rst(sys_rst), .we(cpu_req.wr && hit(cpu_req, `UPR_ADDR_SMODE)),
		.wdata(cpu_req.wdata), .wmask(cpu_req.wmask), .q(smode));

	// Unmapped addresses read as zero.
	always_comb begin
		rdata_next = 8'h00;
		if (hit(cpu_req, `UPR_ADDR_PFUNC1)) begin
			rdata_next = pfunc1;
		end else if (hit(cpu_req, `UPR_ADDR_PDIR1)) begin
			rdata_next = pdir1;
		end else if (hit(cpu_req, `UPR_ADDR_PDIR11)) begin
			rdata_next = pdir11;
		end else if (hit(cpu_req, `UPR_ADDR_ISWC)) begin
			rdata_next = iswc;
		end else if (hit(cpu_req, `UPR_ADDR_SMODE)) begin
			rdata_next = smode;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_reg <= 8'h00;
		end else if (cpu_req.rd) begin
			rdata_reg <= rdata_next;
		end
	end

	assign cpu_rdata = rdata_reg;

	// ==========================================
	// Routing decisions
	upr_route_t route;
	logic power;
	logic txe;
	logic rxe;
	logic tx_eff;
	logic rx113_gated;
	logic rx_sel;
	logic p16_level;
	logic p13_level;
	logic p112_level;

	assign power = smode[`UPR_SM_POWER];
	assign txe = smode[`UPR_SM_TXE];
	assign rxe = smode[`UPR_SM_RXE];

	// Only 01 selects port 1; every prohibited code keeps port 11.
	assign route = (iswc[`UPR_ISWC_PAIR_HI:`UPR_ISWC_PAIR_LO] == 2'b01) ?
		UPR_ROUTE_P1 : UPR_ROUTE_P11;

	// A stopped unit idles its line high so a cut frame ends cleanly.
	assign tx_eff = power ? serial_tx : 1'b1;

	// The ungated input floats after reset, so it reads as idle high.
	assign rx113_gated = iswc[`UPR_ISWC_RX_GATE] ? p113_in : 1'b1;
	assign rx_sel = (route == UPR_ROUTE_P1) ? p15_in : rx113_gated;

	// The transmit function only takes the pin while transmit is enabled.
	assign p16_level = (pfunc1[`UPR_PF_PIN6] && route == UPR_ROUTE_P1 && txe) ? tx_eff :
		(clocked_serial_a_act ? clocked_serial_a_out : port1_latch[6]);
	assign p13_level = pfunc1[`UPR_PF_PIN3] ? serial0_tx :
		(clocked_serial10_act ? clocked_serial10_out : port1_latch[3]);
	assign p112_level = (route == UPR_ROUTE_P11 && txe) ? tx_eff :
		port11_latch[2];

	// ==========================================
	// Pin drivers
	upr_pin_cell u_p16 (.clk(clk), .sys_rst(sys_rst), .level(p16_level),
		.dir_in(pdir1[6]), .drv(p16_drv));
	upr_pin_cell u_p13 (.clk(clk), .sys_rst(sys_rst), .level(p13_level),
		.dir_in(pdir1[3]), .drv(p13_drv));
	upr_pin_cell u_p112 (.clk(clk), .sys_rst(sys_rst), .level(p112_level),
		.dir_in(pdir11[2]), .drv(p112_drv));

	// ==========================================
	// Serial unit and timer inputs
	logic serial_rx_reg;
	logic t00_reg;
	logic int0_reg;
	logic t52_reg;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			serial_rx_reg <= 1'b1;
		end else begin
			serial_rx_reg <= (power && rxe) ? rx_sel : 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			t00_reg <= 1'b0;
			int0_reg <= 1'b0;
			t52_reg <= 1'b0;
		end else begin
			t00_reg <= iswc[`UPR_ISWC_T00_SRC] ? rx_sel : timer00_pin;
			int0_reg <= iswc[`UPR_ISWC_INT0_SRC] ? rx_sel : extint0_pin;
			t52_reg <= iswc[`UPR_ISWC_T52_GATE] ?
				(timer52_pin & timer_h2_output) : timer52_pin;
		end
	end

	assign serial_rx = serial_rx_reg;
	assign timer00_capture_in = t00_reg;
	assign external_interrupt_0 = int0_reg;
	assign timer52_count_in = t52_reg;

	// ==========================================
	// Clock gating and circuit resets
	logic clk_run_reg;
	logic async_rst_reg;
	logic tx_rst_reg;
	logic rx_rst_reg;
	logic [4:0] format_reg;

	// The core treats unit_async_rst as asynchronous; it is glitch free here.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			clk_run_reg <= 1'b0;
			async_rst_reg <= 1'b1;
		end else begin
			clk_run_reg <= power;
			async_rst_reg <= ~power;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_rst_reg <= 1'b1;
			rx_rst_reg <= 1'b1;
		end else begin
			tx_rst_reg <= ~txe;
			rx_rst_reg <= ~rxe;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			format_reg <= 5'(`UPR_RST_SMODE);
		end else begin
			format_reg <= smode[4:0];
		end
	end

	assign unit_clk_run = clk_run_reg;
	assign unit_async_rst = async_rst_reg;
	assign tx_sync_rst = tx_rst_reg;
	assign rx_sync_rst = rx_rst_reg;
	assign serial_format = format_reg;

	// ==========================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_route_p1;
		(route == UPR_ROUTE_P1 && pfunc1[6] && txe && power)
			|=> p16_drv.out == $past(serial_tx);
	endproperty
	a_route_p1: assert property (p_route_p1) else $error("p16 not transmit");

	property p_bad_sel;
		(iswc[5:4] == 2'b11 && txe && power) |=> p112_drv.out == $past(serial_tx);
	endproperty
	a_bad_sel: assert property (p_bad_sel) else $error("bad select left p11");

	property p_gate;
		(!iswc[3] && route == UPR_ROUTE_P11 && power && rxe) |=> serial_rx;
	endproperty
	a_gate: assert property (p_gate) else $error("gated rx not high");

	property p_t00;
		iswc[1] |=> timer00_capture_in == $past(rx_sel);
	endproperty
	a_t00: assert property (p_t00) else $error("timer00 source wrong");

	property p_int0;
		!iswc[0] |=> external_interrupt_0 == $past(extint0_pin);
	endproperty
	a_int0: assert property (p_int0) else $error("int0 source wrong");

	property p_t52;
		(iswc[2] && !timer_h2_output) |=> !timer52_count_in;
	endproperty
	a_t52: assert property (p_t52) else $error("timer52 not gated");

	property p_iswc_top;
		iswc[7:6] == 2'b00 && pdir11[7:4] == 4'hF;
	endproperty
	a_iswc_top: assert property (p_iswc_top) else $error("fixed bits wrong");

	property p_dir;
		1'b1 |=> p16_drv.oe_n == $past(pdir1[6]) && p112_drv.oe_n == $past(pdir11[2]);
	endproperty
	a_dir: assert property (p_dir) else $error("direction wrong");

	property p_port1_pin3_func;
		pfunc1[3] |=> p13_drv.out == $past(serial0_tx);
	endproperty
	a_port1_pin3_func: assert property (p_port1_pin3_func) else $error("p13 not serial0");

	property p_power_off;
		(!power && txe && route == UPR_ROUTE_P11)
			|=> p112_drv.out && unit_async_rst && !unit_clk_run && serial_rx;
	endproperty
	a_power_off: assert property (p_power_off) else $error("power off wrong");

	property p_txe_rst;
		$fell(txe) |=> tx_sync_rst;
	endproperty
	a_txe_rst: assert property (p_txe_rst) else $error("tx reset missing");

	property p_rxe_rst;
		$fell(rxe) |=> rx_sync_rst;
	endproperty
	a_rxe_rst: assert property (p_rxe_rst) else $error("rx reset missing");

endmodule : upr_top

// ==== tb/upr_line_model.sv ====
// Far-side serial line model that resolves the shared port pins.
`timescale 1ns/10ps
module upr_line_model import upr_pkg::*; (
	// Level that the line puts on the receive pins
	input wire logic rx_level,
	// Device pin drives
	input upr_pin_drv_t p16_drv,
	input upr_pin_drv_t p13_drv,
	input upr_pin_drv_t p112_drv,
	// Resolved pin levels
	output logic p16_in,
	output logic p15_in,
	output logic p13_in,
	output logic p112_in,
	output logic p113_in
);
	// ==========================================
	// Pin resolution
	// A released pin rests at its pull-up, so a stale drive never shows.
	assign p16_in = p16_drv.oe_n ? 1'b1 : p16_drv.out;
	assign p13_in = p13_drv.oe_n ? 1'b1 : p13_drv.out;
	assign p112_in = p112_drv.oe_n ? 1'b1 : p112_drv.out;
	assign p15_in = rx_level;
	assign p113_in = rx_level;
endmodule : upr_line_model

// ==== tb/uart_pin_routing_stop_control_tb_top.sv ====
// Self-checking bench for the pin routing and stop control block.
`timescale 1ns/10ps
module uart_pin_routing_stop_control_tb_top import upr_pkg::*;;
	typedef struct {int sel; logic [7:0] exp;} upr_note_t;
	logic clk, sys_rst, chk, rxl, stx, s0tx, t00, ei0, t52, th2;
	logic ca_act, ca_out, c10_act, c10_out, srx, ck_run, a_rst, t_rst, r_rst;
	logic t00c, ei0c, t52c, p16i, p15i, p13i, p112i, p113i;
	logic [7:0] p1l, rdata;
	logic [3:0] p11l;
	logic [4:0] fmt;
	upr_cpu_req_t req;
	upr_pin_drv_t d16, d13, d112;
	upr_note_t q[$];
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	string nm[8] = '{"rdata", "p112", "p16", "p13", "unit", "timer", "rx", "format"};
	logic [15:0] ad[5] = '{16'hff20, 16'hff21, 16'hff2b, 16'hff4f, 16'hff50};
	logic [7:0] rv[5] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'h01};
	logic [7:0] fv[5] = '{8'h48, 8'hff, 8'hff, 8'h3f, 8'hff};
	logic [7:0] zv[5] = '{8'h00, 8'h00, 8'hf0, 8'h00, 8'h00};

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	upr_top DUT (.clk(clk), .sys_rst(sys_rst), .cpu_req(req), .cpu_rdata(rdata),
		.port1_latch(p1l), .port11_latch(p11l), .clocked_serial_a_act(ca_act),
		.clocked_serial_a_out(ca_out), .clocked_serial10_act(c10_act),
		.clocked_serial10_out(c10_out), .serial0_tx(s0tx), .serial_tx(stx),
		.serial_rx(srx), .serial_format(fmt), .unit_clk_run(ck_run),
		.unit_async_rst(a_rst), .tx_sync_rst(t_rst), .rx_sync_rst(r_rst),
		.timer00_pin(t00), .extint0_pin(ei0), .timer52_pin(t52), .timer_h2_output(th2),
		.timer00_capture_in(t00c), .external_interrupt_0(ei0c), .timer52_count_in(t52c),
		.p16_in(p16i), .p15_in(p15i), .p13_in(p13i), .p112_in(p112i), .p113_in(p113i),
		.p16_drv(d16), .p13_drv(d13), .p112_drv(d112));

	upr_line_model PARTNER (.rx_level(rxl), .p16_drv(d16), .p13_drv(d13), .p112_drv(d112),
		.p16_in(p16i), .p15_in(p15i), .p13_in(p13i), .p112_in(p112i), .p113_in(p113i));

	// ==========================================
	// Scoreboard
	function automatic logic [7:0] obs(input int s);
		case (s)
			0: obs = rdata;
			1: obs = {6'h00, d112};
			2: obs = {6'h00, d16};
			3: obs = {6'h00, d13};
			4: obs = {4'h0, ck_run, a_rst, t_rst, r_rst};
			5: obs = {5'h00, t00c, ei0c, t52c};
			6: obs = {7'h00, srx};
			default: obs = {3'h0, fmt};
		endcase
	endfunction : obs

	task automatic cmp(input string n, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask : cmp

	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done

	always @(negedge clk) begin
		upr_note_t n;
		if (chk) begin
			while (q.size() > 0) begin
				n = q.pop_front();
				cmp(nm[n.sel], obs(n.sel), n.exp);
			end
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			bad_count++;
			test_done;
		end
	end

	// ==========================================
	// Drivers
	task automatic step;
		@(posedge clk);
		#1;
	endtask : step

	task automatic ex(input int s, input logic [7:0] e);
		q.push_back('{s, e});
	endtask : ex

	task automatic fire;
		chk = 1'b1;
		step;
		chk = 1'b0;
	endtask : fire

	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		req.wmask = m;
		step;
		req.wr = 1'b0;
		step;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		req.rd = 1'b1;
		req.addr = a;
		step;
		req.rd = 1'b0;
		ex(0, e);
		fire;
	endtask : rd

	// ==========================================
	// Main sequence
	initial begin
		logic [7:0] s, prev, isw, pf, pd1, pd11;
		logic p, t, r, rp, sel;
		req = '0;
		chk = 1'b0;
		sys_rst = 1'b1;
		{rxl, stx, s0tx, t00, ei0, t52, th2, ca_act, ca_out, c10_act, c10_out} = '0;
		p1l = 8'h00;
		p11l = 4'h0;
		prev = 8'h01;
		void'($urandom(32'h1b10));
		repeat (6) @(posedge clk);
		#1 sys_rst = 1'b0;
		for (int i = 0; i < 5; i++) rd(ad[i], rv[i]);
		ex(4, 8'h07);
		ex(6, 8'h01);
		ex(7, 8'h01);
		fire;
		for (int i = 0; i < 5; i++) wr(ad[i], 8'hff, 8'hff);
		for (int i = 0; i < 5; i++) rd(ad[i], fv[i]);
		for (int i = 0; i < 5; i++) wr(ad[i], 8'h00, 8'hff);
		for (int i = 0; i < 5; i++) rd(ad[i], zv[i]);
		wr(16'hff4f, 8'hff, 8'h08);
		rd(16'hff4f, 8'h08);
		wr(16'hff22, 8'hff, 8'hff);
		rd(16'hff22, 8'h00);
		for (int i = 0; i < 48; i++) begin
			s = 8'($urandom);
			isw = {2'b00, i[1:0], 4'($urandom)};
			{p, t, r} = s[7:5];
			rp = (isw[5:4] == 2'b01);
			pf = {1'b0, rp & t & 1'($urandom), 2'b00, 1'($urandom), 3'b000};
			pd1 = (8'($urandom) & ~{1'b0, rp & t, 6'h00}) | {2'b00, rp & r, 5'h00};
			pd11 = (8'($urandom) & ~{5'h00, !rp & t, 2'b00}) | {4'h0, !rp & r, 3'b000};
			wr(16'hff20, pf, 8'hff);
			wr(16'hff21, pd1, 8'hff);
			wr(16'hff2b, pd11, 8'hff);
			wr(16'hff4f, isw, 8'hff);
			// Enables drop before power changes, then power leads the enables.
			wr(16'hff50, prev & 8'h9f, 8'hff);
			wr(16'hff50, s & 8'h9f, 8'hff);
			wr(16'hff50, s, 8'hff);
			prev = s;
			{rxl, stx, s0tx, t00, ei0, t52, th2, ca_act, ca_out, c10_act, c10_out} = 11'($urandom);
			p1l = 8'($urandom);
			p11l = 4'($urandom) | {1'b0, !rp & t, 2'b00};
			step;
			step;
			sel = (rp | isw[3]) ? rxl : 1'b1;
			ex(1, {(!rp & t) ? (p ? stx : 1'b1) : p11l[2], pd11[2]});
			ex(2, {pf[6] ? (p ? stx : 1'b1) : (ca_act ? ca_out : p1l[6]), pd1[6]});
			ex(3, {pf[3] ? s0tx : (c10_act ? c10_out : p1l[3]), pd1[3]});
			ex(4, {4'h0, p, !p, !t, !r});
			ex(5, {5'h00, isw[1] ? sel : t00, isw[0] ? sel : ei0, isw[2] ? t52 & th2 : t52});
			ex(6, {7'h00, (p & r) ? sel : 1'b1});
			ex(7, {3'h0, s[4:0]});
			fire;
		end
		// ==========================================
		// Reset in mid-run must bring every register and the unit back to idle.
		sys_rst = 1'b1;
		step;
		step;
		sys_rst = 1'b0;
		for (int i = 0; i < 5; i++) rd(ad[i], rv[i]);
		ex(1, {p11l[2], 1'b1});
		ex(2, {ca_act ? ca_out : p1l[6], 1'b1});
		ex(4, 8'h07);
		ex(5, {5'h00, t00, ei0, t52});
		ex(6, 8'h01);
		ex(7, 8'h01);
		fire;
		step;
		test_done;
	end
endmodule : uart_pin_routing_stop_control_tb_top
